// >>> shared/cifg_pkg.sv
// constants, register map and field layout of the core interrupt flag block
//
// Notes on behaviour
// - pin edge sets ext flag, bit 1, sticky
// - upper port change sets bit 0, sticky
// - separate peripheral enable register, bit per source
// - peripheral irqs need shared peripheral gate set
// - flags set regardless of any enable bit
// - seven peripheral enables, all reset to zero
package cifg_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CORE_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_PERIPH_EN  = 8'h04;
	localparam logic [7:0] ADDR_PERIPH_FLG = 8'h08;
	localparam logic [7:0] ADDR_TIMER      = 8'h0C;

	// ---------------------------------------------------------------
	// core_interrupt_control field positions
	// ---------------------------------------------------------------
	localparam int CC_GLOBAL_GATE = 7;
	localparam int CC_PERIPH_GATE = 6;
	localparam int CC_TIMER_EN    = 5;
	localparam int CC_EXT_EN      = 4;
	localparam int CC_PORT_EN     = 3;
	localparam int CC_TIMER_FLAG  = 2;
	localparam int CC_EXT_FLAG    = 1;
	localparam int CC_PORT_FLAG   = 0;

	// core flag vector index, same order as bits 2:0
	localparam int FLAG_W         = 3;
	localparam int ENABLE_LSB     = 3;
	localparam int PORT_W         = 4;
	localparam int PERIPH_W       = 8;

	// ---------------------------------------------------------------
	// reset values and masks
	// ---------------------------------------------------------------
	localparam logic [7:0] CORE_CTRL_RST   = 8'h00;
	localparam logic [7:0] PERIPH_EN_RST   = 8'h00;
	localparam logic [7:0] TIMER_RST       = 8'h00;
	localparam logic [7:0] TIMER_MAX       = 8'hFF;
	localparam logic [7:0] TIMER_STEP      = 8'h01;
	localparam logic [7:0] PERIPH_IMPL     = 8'hF7; // bit 3 unimplemented
	localparam logic [2:0] CORE_EN_RST     = 3'h0;
	localparam logic [1:0] GATE_RST        = 2'h0;

endpackage

// >>> src/cifg_edge_det.sv
// change and rising edge detection on synchronous input pins
`timescale 1ns/100ps
module cifg_edge_det #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] chg_o
);

	logic [W-1:0] prev_reg;
	logic [W-1:0] prev_next;

	// previous sample; the first edge after reset compares to low
	always_comb begin
		prev_next = pin_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign rise_o = pin_i & ~prev_reg;
	assign chg_o  = pin_i ^ prev_reg;

	a_change_seen: assert property (@(posedge clk_i) disable iff (rst_i)
		(pin_i != $past(pin_i)) |-> (chg_o != '0))
		else $error("pin change not reported");

endmodule

// >>> src/cifg_sticky.sv
// sticky flag cells: hardware sets, software clears, set wins
`timescale 1ns/100ps
module cifg_sticky #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] flag_reg;
	logic [W-1:0] flag_next;

	// a set in the clearing cycle survives, so no event is lost
	always_comb begin
		flag_next = (flag_reg & ~clr_i) | set_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign q_o = flag_reg;

	a_set_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(|set_i) |=> ((flag_reg & $past(set_i)) == $past(set_i)))
		else $error("flag set event was lost");

	a_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		(set_i == '0 && clr_i == '0) |=> (flag_reg == $past(flag_reg)))
		else $error("flag changed without set or clear");

endmodule

// >>> src/cifg_top.sv
// core interrupt flags, enables and gating behind an apb slave
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module cifg_top
	import cifg_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// apb slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [7:0]          paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// event sources
	input  wire logic                edge_interrupt_pin_i,
	input  wire logic [PORT_W-1:0]   upper_port_pins_i,
	input  wire logic                timer_tick_i,
	input  wire logic [PERIPH_W-1:0] periph_event_i,
	// interrupt request
	output logic                     irq_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic                global_irq_gate_reg;
	logic                global_irq_gate_next;
	logic                peripheral_irq_gate_reg;
	logic                peripheral_irq_gate_next;
	logic [FLAG_W-1:0]   core_en_reg;
	logic [FLAG_W-1:0]   core_en_next;
	logic [PERIPH_W-1:0] peripheral_enable_reg;
	logic [PERIPH_W-1:0] peripheral_enable_next;
	logic [7:0]          timer_zero_count_reg;
	logic [7:0]          timer_zero_count_next;
	logic [31:0]         prdata_reg;
	logic [31:0]         prdata_next;
	logic                pready_reg;
	logic                pready_next;
	logic                pslverr_reg;
	logic                pslverr_next;
	logic                irq_reg;
	logic                irq_next;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic                access;
	logic                wr_en;
	logic                hit_core;
	logic                hit_pen;
	logic                hit_pflg;
	logic                hit_timer;
	logic                mapped;
	logic [7:0]          wbyte;

	// a transfer completes at the edge where pready is already high
	assign access    = psel_i & penable_i;
	assign wr_en     = access & pready_reg & pwrite_i & mapped;
	assign hit_core  = (paddr_i == ADDR_CORE_CTRL);
	assign hit_pen   = (paddr_i == ADDR_PERIPH_EN);
	assign hit_pflg  = (paddr_i == ADDR_PERIPH_FLG);
	assign hit_timer = (paddr_i == ADDR_TIMER);
	assign mapped    = hit_core | hit_pen | hit_pflg | hit_timer;
	assign wbyte     = pwdata_i[7:0];

	// ---------------------------------------------------------------
	// event detection
	// ---------------------------------------------------------------
	logic [0:0]          ext_rise;
	logic [PORT_W-1:0]   port_chg;
	logic                timer_wrap;
	logic                timer_wr;

	cifg_edge_det #(.W(1)) u_ext_edge (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (edge_interrupt_pin_i),
		.rise_o (ext_rise),
		.chg_o  ()
	);

	cifg_edge_det #(.W(PORT_W)) u_port_chg (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (upper_port_pins_i),
		.rise_o (),
		.chg_o  (port_chg)
	);

	// a software write of the count wins over the tick, so no wrap then
	assign timer_wr   = wr_en & hit_timer;
	assign timer_wrap = timer_tick_i & ~timer_wr & (timer_zero_count_reg == TIMER_MAX);

	// ---------------------------------------------------------------
	// sticky flags
	// ---------------------------------------------------------------
	logic [FLAG_W-1:0]   core_flag_set;
	logic [FLAG_W-1:0]   core_flag_clr;
	logic [FLAG_W-1:0]   core_flags;
	logic [PERIPH_W-1:0] pflag_set;
	logic [PERIPH_W-1:0] pflag_clr;
	logic [PERIPH_W-1:0] pflags;

	// flags set on their event alone, whatever the enables hold
	always_comb begin
		core_flag_set                = '0;
		core_flag_set[CC_TIMER_FLAG] = timer_wrap;
		core_flag_set[CC_EXT_FLAG]   = ext_rise[0];
		core_flag_set[CC_PORT_FLAG]  = |port_chg;
		core_flag_clr                = '0;
		if (wr_en && hit_core) begin
			core_flag_clr = wbyte[FLAG_W-1:0];           // write one to clear
		end
		pflag_set = periph_event_i & PERIPH_IMPL;
		pflag_clr = '0;
		if (wr_en && hit_pflg) begin
			pflag_clr = wbyte & PERIPH_IMPL;
		end
	end

	cifg_sticky #(.W(FLAG_W)) u_core_flags (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.set_i (core_flag_set),
		.clr_i (core_flag_clr),
		.q_o   (core_flags)
	);

	cifg_sticky #(.W(PERIPH_W)) u_periph_flags (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.set_i (pflag_set),
		.clr_i (pflag_clr),
		.q_o   (pflags)
	);

	// ---------------------------------------------------------------
	// control registers and timer
	// ---------------------------------------------------------------
	always_comb begin
		global_irq_gate_next     = global_irq_gate_reg;
		peripheral_irq_gate_next = peripheral_irq_gate_reg;
		core_en_next             = core_en_reg;
		peripheral_enable_next   = peripheral_enable_reg;
		timer_zero_count_next    = timer_zero_count_reg;
		if (wr_en && hit_core) begin
			global_irq_gate_next     = wbyte[CC_GLOBAL_GATE];
			peripheral_irq_gate_next = wbyte[CC_PERIPH_GATE];
			core_en_next             = wbyte[ENABLE_LSB +: FLAG_W];
		end
		if (wr_en && hit_pen) begin
			peripheral_enable_next = wbyte & PERIPH_IMPL;
		end
		if (timer_wr) begin
			timer_zero_count_next = wbyte;
		end else if (timer_tick_i) begin
			timer_zero_count_next = timer_zero_count_reg + TIMER_STEP; // wraps to zero
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			global_irq_gate_reg     <= GATE_RST[1];
			peripheral_irq_gate_reg <= GATE_RST[0];
			core_en_reg             <= CORE_EN_RST;
			peripheral_enable_reg   <= PERIPH_EN_RST;
			timer_zero_count_reg    <= TIMER_RST;
		end else begin
			global_irq_gate_reg     <= global_irq_gate_next;
			peripheral_irq_gate_reg <= peripheral_irq_gate_next;
			core_en_reg             <= core_en_next;
			peripheral_enable_reg   <= peripheral_enable_next;
			timer_zero_count_reg    <= timer_zero_count_next;
		end
	end

	// ---------------------------------------------------------------
	// apb answer and read mux
	// ---------------------------------------------------------------
	logic [7:0] core_view;

	assign core_view = {global_irq_gate_reg, peripheral_irq_gate_reg, core_en_reg, core_flags};

	// one wait state: pready rises in the second access cycle
	always_comb begin
		pready_next  = access & ~pready_reg;
		pslverr_next = access & ~pready_reg & ~mapped;
		prdata_next  = '0;
		if (access && !pready_reg && !pwrite_i) begin
			unique case (1'b1)
				hit_core:  prdata_next[7:0] = core_view;
				hit_pen:   prdata_next[7:0] = peripheral_enable_reg;
				hit_pflg:  prdata_next[7:0] = pflags;
				hit_timer: prdata_next[7:0] = timer_zero_count_reg;
				default:   prdata_next      = '0; // unmapped reads zero
			endcase
		end
	end

	// ---------------------------------------------------------------
	// interrupt gating
	// ---------------------------------------------------------------
	logic core_pending;
	logic periph_pending;

	// peripheral sources pass only through the shared peripheral gate
	assign core_pending   = |(core_en_reg & core_flags);
	assign periph_pending = peripheral_irq_gate_reg & |(peripheral_enable_reg & pflags);

	always_comb begin
		irq_next = global_irq_gate_reg & (core_pending | periph_pending);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg     <= irq_next;
		end
	end

	assign prdata_o  = prdata_reg;
	assign pready_o  = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign irq_o     = irq_reg;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_ext_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(edge_interrupt_pin_i && !$past(edge_interrupt_pin_i)) |=> core_view[CC_EXT_FLAG])
		else $error("pin edge did not set ext flag");

	a_port_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(upper_port_pins_i != $past(upper_port_pins_i)) |=> core_view[CC_PORT_FLAG])
		else $error("port change did not set port flag");

	a_pen_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && hit_pen) |=> (peripheral_enable_reg == ($past(wbyte) & PERIPH_IMPL)))
		else $error("peripheral enable write not stored");

	a_periph_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(!peripheral_irq_gate_reg && !core_pending) |=> !irq_o)
		else $error("peripheral irq passed closed gate");

	a_timer_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(timer_tick_i && !timer_wr && timer_zero_count_reg == TIMER_MAX)
		|=> (core_flags[CC_TIMER_FLAG] && timer_zero_count_reg == TIMER_RST))
		else $error("timer wrap missed");

	a_flag_no_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		(periph_event_i[0] && peripheral_enable_reg[0] == 1'b0) |=> pflags[0])
		else $error("flag blocked by disabled enable");

	a_enables_reset: assert property (@(posedge clk_i)
		$fell(rst_i) |-> (peripheral_enable_reg == PERIPH_EN_RST))
		else $error("peripheral enables not zero after reset");

	a_apb_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		(psel_i && !penable_i) ##1 (psel_i && penable_i) |-> !pready_o ##1 pready_o)
		else $error("apb answer timing wrong");

	// the answer lasts one cycle, so a held select cannot complete in two cycles running
	a_ready_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		pready_o |=> !pready_o)
		else $error("pready held longer than one cycle");

	a_err_with_ready: assert property (@(posedge clk_i) disable iff (rst_i)
		pslverr_o |-> pready_o)
		else $error("error response without pready");

	// read data is zero outside the answer cycle, so a late sample sees nothing stale
	a_rdata_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		!pready_o |-> (prdata_o == 32'h0))
		else $error("read data not zero outside answer");

	// gating paths: the global gate blocks all, every open path must reach irq
	a_global_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!global_irq_gate_reg |=> !irq_o)
		else $error("irq raised with global gate closed");

	a_core_irq_path: assert property (@(posedge clk_i) disable iff (rst_i)
		(global_irq_gate_reg && core_pending) |=> irq_o)
		else $error("enabled core flag did not raise irq");

	a_periph_irq_path: assert property (@(posedge clk_i) disable iff (rst_i)
		(global_irq_gate_reg && peripheral_irq_gate_reg
			&& (peripheral_enable_reg & pflags) != 8'h00) |=> irq_o)
		else $error("enabled peripheral flag did not raise irq");

	a_ext_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && hit_core && wbyte[CC_EXT_FLAG] && !core_flag_set[CC_EXT_FLAG])
		|=> !core_flags[CC_EXT_FLAG])
		else $error("ext flag not cleared by write one");

endmodule

// >>> tb/tb_top.sv
// self-checking bench for the core interrupt flag block, apb register access
`timescale 1ns/100ps
module tb_top
	import cifg_pkg::*;
;
	logic                clk_i;
	logic                rst_i;
	logic                psel_i;
	logic                penable_i;
	logic                pwrite_i;
	logic [7:0]          paddr_i;
	logic [31:0]         pwdata_i;
	logic [31:0]         prdata_o;
	logic                pready_o;
	logic                pslverr_o;
	logic                edge_interrupt_pin_i;
	logic [PORT_W-1:0]   upper_port_pins_i;
	logic                timer_tick_i;
	logic [PERIPH_W-1:0] periph_event_i;
	logic                irq_o;
	int                  mismatches;
	int                  checks_done;

	cifg_top cifg_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .edge_interrupt_pin_i(edge_interrupt_pin_i),
		.upper_port_pins_i(upper_port_pins_i), .timer_tick_i(timer_tick_i),
		.periph_event_i(periph_event_i), .irq_o(irq_o)
	);

	// ---------------------------------------------------------------
	// clock, closing and watchdog
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic stop_test();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// the tests need well under a thousand cycles; this only cuts a hang
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// shared checks and apb master
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// holds the request until pready is seen high at an edge, then one idle cycle
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel_i <= 1'h1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 20);
		rd = prdata_o;
		err = pslverr_o;
		if (n >= 20) chk(32'h0, 32'h1, "apb answer");
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] rd;
		logic        err;
		apb(1'h1, a, d, rd, err);
		chk({31'h0, err}, {31'h0, exp_err}, "write error flag");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic        err;
		apb(1'h0, a, 32'h0, rd, err);
		chk(rd, exp, "read data");
		chk({31'h0, err}, {31'h0, exp_err}, "read error flag");
	endtask

	// irq lags its cause by a cycle, so let a few edges pass first
	task automatic irq_chk(input logic exp);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq_o}, {31'h0, exp}, "irq level");
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rd_chk(ADDR_CORE_CTRL, 32'h0, 1'h0);
		rd_chk(ADDR_PERIPH_EN, 32'h0, 1'h0);
		rd_chk(ADDR_PERIPH_FLG, 32'h0, 1'h0);
		rd_chk(ADDR_TIMER, 32'h0, 1'h0);
	endtask

	task automatic t_unmapped();
		wr_reg(8'h10, 32'hFF, 1'h1);
		rd_chk(8'h10, 32'h0, 1'h1);
	endtask

	task automatic t_ext();
		edge_interrupt_pin_i <= 1'h1;
		irq_chk(1'h0);
		edge_interrupt_pin_i <= 1'h0;
		rd_chk(ADDR_CORE_CTRL, 32'h02, 1'h0);
		wr_reg(ADDR_CORE_CTRL, 32'h90, 1'h0);
		rd_chk(ADDR_CORE_CTRL, 32'h92, 1'h0);
		irq_chk(1'h1);
		wr_reg(ADDR_CORE_CTRL, 32'h92, 1'h0);
		rd_chk(ADDR_CORE_CTRL, 32'h90, 1'h0);
		irq_chk(1'h0);
	endtask

	task automatic t_port();
		rd_chk(ADDR_CORE_CTRL, 32'h90, 1'h0);
		upper_port_pins_i <= 4'h8;
		repeat (2) @(posedge clk_i);
		rd_chk(ADDR_CORE_CTRL, 32'h91, 1'h0);
		irq_chk(1'h0);
		wr_reg(ADDR_CORE_CTRL, 32'h88, 1'h0);
		rd_chk(ADDR_CORE_CTRL, 32'h89, 1'h0);
		irq_chk(1'h1);
		wr_reg(ADDR_CORE_CTRL, 32'h01, 1'h0);
		rd_chk(ADDR_CORE_CTRL, 32'h00, 1'h0);
	endtask

	task automatic t_timer();
		wr_reg(ADDR_TIMER, 32'hFE, 1'h0);
		timer_tick_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		timer_tick_i <= 1'h0;
		rd_chk(ADDR_TIMER, 32'h00, 1'h0);
		rd_chk(ADDR_CORE_CTRL, 32'h04, 1'h0);
		wr_reg(ADDR_CORE_CTRL, 32'hA0, 1'h0);
		rd_chk(ADDR_CORE_CTRL, 32'hA4, 1'h0);
		irq_chk(1'h1);
		wr_reg(ADDR_CORE_CTRL, 32'h04, 1'h0);
		rd_chk(ADDR_CORE_CTRL, 32'h00, 1'h0);
		irq_chk(1'h0);
	endtask

	// the event comes while every enable is still zero; bit 3 has no flag
	task automatic t_periph();
		periph_event_i <= 8'h09;
		@(posedge clk_i);
		periph_event_i <= 8'h00;
		rd_chk(ADDR_PERIPH_FLG, 32'h01, 1'h0);
		wr_reg(ADDR_PERIPH_EN, 32'hFF, 1'h0);
		rd_chk(ADDR_PERIPH_EN, 32'hF7, 1'h0);
		wr_reg(ADDR_CORE_CTRL, 32'h80, 1'h0);
		irq_chk(1'h0);
		wr_reg(ADDR_CORE_CTRL, 32'hC0, 1'h0);
		irq_chk(1'h1);
		wr_reg(ADDR_PERIPH_EN, 32'hFE, 1'h0);
		irq_chk(1'h0);
		wr_reg(ADDR_PERIPH_FLG, 32'h01, 1'h0);
		rd_chk(ADDR_PERIPH_FLG, 32'h00, 1'h0);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		mismatches = 0;
		checks_done = 0;
		rst_i = 1'h1;
		psel_i = 1'h0;
		penable_i = 1'h0;
		pwrite_i = 1'h0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		edge_interrupt_pin_i = 1'h0;
		upper_port_pins_i = 4'h0;
		timer_tick_i = 1'h0;
		periph_event_i = 8'h00;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_unmapped();
		t_ext();
		t_port();
		t_timer();
		t_periph();
		stop_test();
	end
endmodule
